// file: shared/mpk_port_pkg.sv
// Register map, field positions and reset values of the port block.
package mpk_port_pkg;
   localparam logic [15:0] ADDR_P0_LATCH = 16'hff00;
   localparam logic [15:0] ADDR_P1_PINS  = 16'hff01;
   localparam logic [15:0] ADDR_P2_LATCH = 16'hff02;
   localparam logic [15:0] ADDR_P4_LATCH = 16'hff04;
   localparam logic [15:0] ADDR_P5_LATCH = 16'hff05;
   localparam logic [15:0] ADDR_P6_LATCH = 16'hff06;
   localparam logic [15:0] ADDR_P7_LATCH = 16'hff07;
   localparam logic [15:0] ADDR_P0_DIR   = 16'hff20;
   localparam logic [15:0] ADDR_P2_DIR   = 16'hff22;
   localparam logic [15:0] ADDR_P4_DIR   = 16'hff24;
   localparam logic [15:0] ADDR_P5_DIR   = 16'hff25;
   localparam logic [15:0] ADDR_P6_DIR   = 16'hff26;
   localparam logic [15:0] ADDR_P7_DIR   = 16'hff27;
   localparam logic [15:0] ADDR_P0_PU    = 16'hff30;
   localparam logic [15:0] ADDR_P2_PU    = 16'hff32;
   localparam logic [15:0] ADDR_P4_PU    = 16'hff34;
   localparam logic [15:0] ADDR_P5_PU    = 16'hff35;
   localparam logic [15:0] ADDR_P6_PU    = 16'hff36;
   localparam logic [15:0] ADDR_P7_PU    = 16'hff37;
   localparam logic [15:0] ADDR_DRV_TYPE = 16'hff42;
   localparam logic [15:0] ADDR_MEM_EXP  = 16'hff40;
   localparam logic [15:0] ADDR_KEY_RET  = 16'hff47;
   localparam logic [7:0]  DIR_RESET     = 8'hff;
   localparam logic [7:0]  PU_RESET      = 8'h00;
   localparam logic [7:0]  LATCH_RESET   = 8'h00;
   localparam logic [2:0]  DRV_RESET     = 3'h0;
   localparam logic        KEY_EN_RESET  = 1'b0;
   localparam logic        MEM_DIR_RESET = 1'b1;
   localparam int          KEY_EN_BIT    = 0;
   localparam int          MEM_DIR_BIT   = 0;
   localparam int          OD_PINS       = 3;
   localparam logic [7:0]  P0_USED_MASK  = 8'h0f;
   localparam logic [7:0]  P7_USED_MASK  = 8'h03;
endpackage

// file: src/mpk_port_block.sv
// Seven-port general-purpose I/O block with bit and byte register access.
`timescale 1ns/1ps
module mpk_port_block
   import mpk_port_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   input  wire logic        cpu_bit_op,
   input  wire logic [2:0]  cpu_bit_sel,
   input  wire logic [7:0]  cpu_wdata,
   output logic      [7:0]  cpu_rdata,
   input  wire logic [3:0]  p0_in,
   output logic      [3:0]  p0_out,
   output logic      [3:0]  p0_oe,
   output logic      [3:0]  p0_pu,
   output logic      [3:0]  p0_int_req,
   input  wire logic [7:0]  p1_in,
   input  wire logic [7:0]  p2_in,
   output logic      [7:0]  p2_out,
   output logic      [7:0]  p2_oe,
   output logic      [7:0]  p2_pu,
   input  wire logic [7:0]  p4_in,
   output logic      [7:0]  p4_out,
   output logic      [7:0]  p4_oe,
   output logic      [7:0]  p4_pu,
   output logic             key_int_req,
   input  wire logic [7:0]  p5_in,
   output logic      [7:0]  p5_out,
   output logic      [7:0]  p5_oe,
   output logic      [7:0]  p5_pu,
   input  wire logic [7:0]  p6_in,
   output logic      [7:0]  p6_out,
   output logic      [7:0]  p6_oe,
   output logic      [7:0]  p6_pu,
   input  wire logic [1:0]  p7_in,
   output logic      [1:0]  p7_out,
   output logic      [1:0]  p7_oe,
   output logic      [1:0]  p7_pu
);

   // A bit operation rewrites only the selected bit; a byte write takes all eight.
   function automatic logic [7:0] merge_write(
      input logic [7:0] old_val,
      input logic [7:0] wdata,
      input logic       bit_op,
      input logic [2:0] bit_sel
   );
      return bit_op ? ((old_val & ~(8'h01 << bit_sel)) | (wdata & (8'h01 << bit_sel))) : wdata;
   endfunction

   function automatic logic [7:0] port_view(
      input logic [7:0] dir,
      input logic [7:0] latch,
      input logic [7:0] pins
   );
      return (dir & pins) | (~dir & latch);
   endfunction

   logic [7:0] p0_dir_reg;
   logic [7:0] p2_dir_reg;
   logic [7:0] p4_dir_reg;
   logic [7:0] p5_dir_reg;
   logic [7:0] p6_dir_reg;
   logic [7:0] p7_dir_reg;
   logic [7:0] p0_pu_reg;
   logic [7:0] p2_pu_reg;
   logic [7:0] p4_pu_reg;
   logic [7:0] p5_pu_reg;
   logic [7:0] p6_pu_reg;
   logic [7:0] p7_pu_reg;
   logic [7:0] p0_lat_reg;
   logic [7:0] p2_lat_reg;
   logic [7:0] p4_lat_reg;
   logic [7:0] p5_lat_reg;
   logic [7:0] p6_lat_reg;
   logic [7:0] p7_lat_reg;
   logic [2:0] drv_type_reg;
   logic       key_en_reg;
   logic       mem_dir_reg;
   logic [3:0] p0_prev_reg;
   logic       wr;
   logic [7:0] p4_dir_eff;
   logic [7:0] p0_dir8;
   logic [7:0] p7_dir8;
   logic [7:0] rd_next;

   assign wr         = ce & cpu_wr;
   assign p4_dir_eff = {8{mem_dir_reg}};
   assign p0_dir8    = p0_dir_reg | ~P0_USED_MASK;
   assign p7_dir8    = p7_dir_reg | ~P7_USED_MASK;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         p0_dir_reg <= DIR_RESET;
         p2_dir_reg <= DIR_RESET;
         p4_dir_reg <= DIR_RESET;
         p5_dir_reg <= DIR_RESET;
         p6_dir_reg <= DIR_RESET;
         p7_dir_reg <= DIR_RESET;
      end
      else if (wr)
      begin
         unique case (cpu_addr)
            ADDR_P0_DIR:
               p0_dir_reg <= merge_write(p0_dir_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel)
                             | ~P0_USED_MASK;
            ADDR_P2_DIR:
               p2_dir_reg <= merge_write(p2_dir_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P4_DIR:
               p4_dir_reg <= merge_write(p4_dir_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P5_DIR:
               p5_dir_reg <= merge_write(p5_dir_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P6_DIR:
               p6_dir_reg <= merge_write(p6_dir_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P7_DIR:
               p7_dir_reg <= merge_write(p7_dir_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel)
                             | ~P7_USED_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         p0_pu_reg <= PU_RESET;
         p2_pu_reg <= PU_RESET;
         p4_pu_reg <= PU_RESET;
         p5_pu_reg <= PU_RESET;
         p6_pu_reg <= PU_RESET;
         p7_pu_reg <= PU_RESET;
      end
      else if (wr)
      begin
         unique case (cpu_addr)
            ADDR_P0_PU:
               p0_pu_reg <= merge_write(p0_pu_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel)
                            & P0_USED_MASK;
            ADDR_P2_PU:
               p2_pu_reg <= merge_write(p2_pu_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P4_PU:
               p4_pu_reg <= merge_write(p4_pu_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P5_PU:
               p5_pu_reg <= merge_write(p5_pu_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P6_PU:
               p6_pu_reg <= merge_write(p6_pu_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P7_PU:
               p7_pu_reg <= merge_write(p7_pu_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel)
                            & P7_USED_MASK;
            default: ;
         endcase
      end
   end

   // Output latches. A bit write merges into the latch itself, not into the
   // pin view, so input-pin latch bits keep their last written value.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         p0_lat_reg <= LATCH_RESET;
         p2_lat_reg <= LATCH_RESET;
         p4_lat_reg <= LATCH_RESET;
         p5_lat_reg <= LATCH_RESET;
         p6_lat_reg <= LATCH_RESET;
         p7_lat_reg <= LATCH_RESET;
      end
      else if (wr)
      begin
         unique case (cpu_addr)
            ADDR_P0_LATCH:
               p0_lat_reg <= merge_write(p0_lat_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel)
                             & P0_USED_MASK;
            ADDR_P2_LATCH:
               p2_lat_reg <= merge_write(p2_lat_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P4_LATCH:
               p4_lat_reg <= merge_write(p4_lat_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P5_LATCH:
               p5_lat_reg <= merge_write(p5_lat_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P6_LATCH:
               p6_lat_reg <= merge_write(p6_lat_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel);
            ADDR_P7_LATCH:
               p7_lat_reg <= merge_write(p7_lat_reg, cpu_wdata, cpu_bit_op, cpu_bit_sel)
                             & P7_USED_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         drv_type_reg <= DRV_RESET;
         key_en_reg   <= KEY_EN_RESET;
         mem_dir_reg  <= MEM_DIR_RESET;
      end
      else if (wr)
      begin
         unique case (cpu_addr)
            ADDR_DRV_TYPE:
               drv_type_reg <= 3'(merge_write({5'h00, drv_type_reg}, cpu_wdata,
                                              cpu_bit_op, cpu_bit_sel));
            ADDR_KEY_RET:
               key_en_reg <= (cpu_bit_op && cpu_bit_sel != 3'(KEY_EN_BIT)) ? key_en_reg
                             : cpu_wdata[KEY_EN_BIT];
            ADDR_MEM_EXP:
               mem_dir_reg <= (cpu_bit_op && cpu_bit_sel != 3'(MEM_DIR_BIT)) ? mem_dir_reg
                              : cpu_wdata[MEM_DIR_BIT];
            default: ;
         endcase
      end
   end

   // Read data path; one cycle after the request, unmapped addresses give zero.
   always_comb
   begin
      unique case (cpu_addr)
         ADDR_P0_LATCH: rd_next = port_view(p0_dir8, p0_lat_reg, {4'h0, p0_in});
         ADDR_P1_PINS:  rd_next = p1_in;
         ADDR_P2_LATCH: rd_next = port_view(p2_dir_reg, p2_lat_reg, p2_in);
         ADDR_P4_LATCH: rd_next = port_view(p4_dir_eff, p4_lat_reg, p4_in);
         ADDR_P5_LATCH: rd_next = port_view(p5_dir_reg, p5_lat_reg, p5_in);
         ADDR_P6_LATCH: rd_next = port_view(p6_dir_reg, p6_lat_reg, p6_in);
         ADDR_P7_LATCH: rd_next = port_view(p7_dir8, p7_lat_reg, {6'h00, p7_in});
         ADDR_P0_DIR:   rd_next = p0_dir8;
         ADDR_P2_DIR:   rd_next = p2_dir_reg;
         ADDR_P4_DIR:   rd_next = p4_dir_reg;
         ADDR_P5_DIR:   rd_next = p5_dir_reg;
         ADDR_P6_DIR:   rd_next = p6_dir_reg;
         ADDR_P7_DIR:   rd_next = p7_dir8;
         ADDR_P0_PU:    rd_next = p0_pu_reg;
         ADDR_P2_PU:    rd_next = p2_pu_reg;
         ADDR_P4_PU:    rd_next = p4_pu_reg;
         ADDR_P5_PU:    rd_next = p5_pu_reg;
         ADDR_P6_PU:    rd_next = p6_pu_reg;
         ADDR_P7_PU:    rd_next = p7_pu_reg;
         ADDR_DRV_TYPE: rd_next = {5'h00, drv_type_reg};
         ADDR_KEY_RET:  rd_next = {7'h00, key_en_reg};
         ADDR_MEM_EXP:  rd_next = {7'h00, mem_dir_reg};
         default:       rd_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         cpu_rdata <= 8'h00;
      else if (ce && cpu_rd)
         cpu_rdata <= rd_next;
   end

   // Pin drivers. Open-drain pins on port 2 only sink: they enable the driver
   // when the latch holds 0 and float otherwise.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         p0_out <= 4'h0;
         p0_oe  <= 4'h0;
         p2_out <= 8'h00;
         p2_oe  <= 8'h00;
         p4_out <= 8'h00;
         p4_oe  <= 8'h00;
         p5_out <= 8'h00;
         p5_oe  <= 8'h00;
         p6_out <= 8'h00;
         p6_oe  <= 8'h00;
         p7_out <= 2'h0;
         p7_oe  <= 2'h0;
      end
      else if (ce)
      begin
         p0_out <= p0_lat_reg[3:0];
         p0_oe  <= ~p0_dir_reg[3:0];
         p2_out <= p2_lat_reg;
         p2_oe  <= ~p2_dir_reg & ~({5'h00, drv_type_reg} & p2_lat_reg);
         p4_out <= p4_lat_reg;
         p4_oe  <= ~p4_dir_eff;
         p5_out <= p5_lat_reg;
         p5_oe  <= ~p5_dir_reg;
         p6_out <= p6_lat_reg;
         p6_oe  <= ~p6_dir_reg;
         p7_out <= p7_lat_reg[1:0];
         p7_oe  <= ~p7_dir_reg[1:0];
      end
   end

   // Pull-ups act only while the pin is an input.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         p0_pu <= 4'h0;
         p2_pu <= 8'h00;
         p4_pu <= 8'h00;
         p5_pu <= 8'h00;
         p6_pu <= 8'h00;
         p7_pu <= 2'h0;
      end
      else if (ce)
      begin
         p0_pu <= p0_pu_reg[3:0] & p0_dir_reg[3:0];
         p2_pu <= p2_pu_reg & p2_dir_reg;
         p4_pu <= p4_pu_reg & p4_dir_eff;
         p5_pu <= p5_pu_reg & p5_dir_reg;
         p6_pu <= p6_pu_reg & p6_dir_reg;
         p7_pu <= p7_pu_reg[1:0] & p7_dir_reg[1:0];
      end
   end

   // Port 0 pins feed the interrupt inputs whatever their direction, so driving a new level
   // also fires a request. The history follows the pins in reset, so no false edge follows.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         p0_prev_reg <= p0_in;
         p0_int_req  <= 4'h0;
      end
      else if (ce)
      begin
         p0_prev_reg <= p0_in;
         p0_int_req  <= p0_in ^ p0_prev_reg;
      end
   end

   // Key-return request is a level: any port 4 input pin held low.
   always_ff @(posedge clk)
   begin
      if (!nrst)
         key_int_req <= 1'b0;
      else if (ce)
         key_int_req <= key_en_reg & |(~p4_in & p4_dir_eff);
   end

endmodule // mpk_port_block

// file: dv/mpk_pin_model.sv
// Pin-side model of all bidirectional ports: drivers, pull-ups and bench drive.
`timescale 1ns/1ps
module mpk_pin_model
#(
   parameter int W = 8
)
(
   input  wire logic         clk,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pu,
   input  wire logic [W-1:0] ext,
   input  wire logic [W-1:0] ext_en,
   output logic      [W-1:0] pin
);
   logic [W-1:0] hold = '0;
   // A floating pin without a pull-up shows the opposite of its last level so a stale value never passes; a pulled-up one reads 1.
   assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | ~hold));
   always @(posedge clk)
      hold <= pin;
endmodule // mpk_pin_model

// file: dv/mpk_port_props.sv
// Concurrent checks on the port block's ports.
`timescale 1ns/1ps
module mpk_port_props
   import mpk_port_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [15:0] cpu_addr,
   input wire logic        cpu_wr,
   input wire logic        cpu_rd,
   input wire logic        cpu_bit_op,
   input wire logic [7:0]  cpu_wdata,
   input wire logic [7:0]  cpu_rdata,
   input wire logic [3:0]  p0_in,
   input wire logic [3:0]  p0_oe,
   input wire logic [3:0]  p0_pu,
   input wire logic [3:0]  p0_int_req,
   input wire logic [7:0]  p1_in,
   input wire logic [7:0]  p4_in,
   input wire logic [7:0]  p4_oe,
   input wire logic        key_int_req,
   input wire logic [7:0]  p5_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_p5_byte;
      cpu_wr && !cpu_bit_op && cpu_addr == ADDR_P5_DIR;
   endsequence
   sequence s_p5_quiet;
      !(cpu_wr && cpu_addr == ADDR_P5_DIR);
   endsequence
   property p_p5_dir;
      s_p5_byte ##1 s_p5_quiet |=> p5_oe == ~$past(cpu_wdata, 2);
   endproperty
   property p_p0_int;
      p0_int_req == ($past(p0_in) ^ $past(p0_in, 2));
   endproperty
   property p_p0_pu;
      (p0_pu & p0_oe) == 4'h0;
   endproperty
   property p_p1_read;
      cpu_rd && cpu_addr == ADDR_P1_PINS |=> cpu_rdata == $past(p1_in);
   endproperty
   property p_rdata_hold;
      !cpu_rd |=> $stable(cpu_rdata);
   endproperty
   property p_p7_dir_ones;
      cpu_rd && cpu_addr == ADDR_P7_DIR |=> cpu_rdata[7:2] == 6'h3f;
   endproperty
   property p_p4_group;
      p4_oe == 8'h00 || p4_oe == 8'hff;
   endproperty
   property p_key_low;
      key_int_req |-> $past(p4_in) != 8'hff;
   endproperty
   a_p5_dir: assert property (p_p5_dir)
      else $error("port5 enables do not follow direction write");
   a_p0_int: assert property (p_p0_int)
      else $error("port0 request does not match pin change");
   a_p0_pu: assert property (p_p0_pu)
      else $error("port0 pull-up on an output pin");
   a_p1_read: assert property (p_p1_read)
      else $error("port1 read differs from pins");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");
   a_p7_dir_ones: assert property (p_p7_dir_ones)
      else $error("port7 unused direction bits not one");
   a_p4_group: assert property (p_p4_group)
      else $error("port4 enables not set as a group");
   a_key_low: assert property (p_key_low)
      else $error("key request without a low pin");
endmodule // mpk_port_props
bind mpk_port_block mpk_port_props mpk_port_props_i (.clk(clk), .nrst(nrst),
   .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_bit_op(cpu_bit_op),
   .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .p0_in(p0_in), .p0_oe(p0_oe),
   .p0_pu(p0_pu), .p0_int_req(p0_int_req), .p1_in(p1_in), .p4_in(p4_in),
   .p4_oe(p4_oe), .key_int_req(key_int_req), .p5_oe(p5_oe));

// file: dv/mpk_port_block_bench.sv
// Self-checking bench for the port block.
`timescale 1ns/1ps
module mpk_port_block_bench
   import mpk_port_pkg::*;
;
   logic        clk = 0, nrst = 0, ce = 1, cpu_wr = 0, cpu_rd = 0, cpu_bit_op = 0;
   logic [15:0] cpu_addr = 0;
   logic [2:0]  cpu_bit_sel = 0;
   logic [7:0]  cpu_wdata = 0, p1_in = 0, cpu_rdata;
   logic [3:0]  p0_in, p0_out, p0_oe, p0_pu, p0_int_req;
   logic [7:0]  p2_in, p2_out, p2_oe, p2_pu, p4_in, p4_out, p4_oe, p4_pu;
   logic [7:0]  p5_in, p5_out, p5_oe, p5_pu, p6_in, p6_out, p6_oe, p6_pu;
   logic [1:0]  p7_in, p7_out, p7_oe, p7_pu;
   logic        key_int_req;
   logic [37:0] pins, ext = 38'h00000ff000, ext_en = '1;
   logic [15:0] dirs [6] = '{ADDR_P0_DIR, ADDR_P2_DIR, ADDR_P4_DIR, ADDR_P5_DIR,
                             ADDR_P6_DIR, ADDR_P7_DIR};
   int          fails = 0, compares = 0, cyc = 0;
   always #2.5 clk = ~clk;
   mpk_port_block mpk_port_block_i (.clk(clk), .nrst(nrst), .ce(ce), .cpu_addr(cpu_addr),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .p0_in(p0_in), .p0_out(p0_out),
      .p0_oe(p0_oe), .p0_pu(p0_pu), .p0_int_req(p0_int_req), .p1_in(p1_in), .p2_in(p2_in),
      .p2_out(p2_out), .p2_oe(p2_oe), .p2_pu(p2_pu), .p4_in(p4_in), .p4_out(p4_out),
      .p4_oe(p4_oe), .p4_pu(p4_pu), .key_int_req(key_int_req), .p5_in(p5_in),
      .p5_out(p5_out), .p5_oe(p5_oe), .p5_pu(p5_pu), .p6_in(p6_in), .p6_out(p6_out),
      .p6_oe(p6_oe), .p6_pu(p6_pu), .p7_in(p7_in), .p7_out(p7_out), .p7_oe(p7_oe),
      .p7_pu(p7_pu));
   mpk_pin_model #(.W(38)) mpk_pin_model_i (.clk(clk),
      .out({p7_out, p6_out, p5_out, p4_out, p2_out, p0_out}),
      .oe({p7_oe, p6_oe, p5_oe, p4_oe, p2_oe, p0_oe}),
      .pu({p7_pu, p6_pu, p5_pu, p4_pu, p2_pu, p0_pu}),
      .ext(ext), .ext_en(ext_en), .pin(pins));
   assign {p7_in, p6_in, p5_in, p4_in, p2_in, p0_in} = pins;
   task automatic complete_run;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
                     input logic [2:0] s = 3'h0);
      @(posedge clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_bit_op <= b;
      cpu_bit_sel <= s;
      cpu_wr <= 1'b1;
      @(posedge clk);
      cpu_wr <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge clk);
      cpu_rd <= 1'b0;
      #1;
      chk(n, e, cpu_rdata);
   endtask
   // Pin outputs trail the register by one cycle, so two edges always suffice.
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic wait_flag(input bit key);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         #1;
         if (key ? key_int_req === 1'b1 : p0_int_req !== 4'h0)
            break;
      end
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fails++;
         complete_run;
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      foreach (dirs[k])
         rd("direction", dirs[k], 8'hff);
      chk("p2_oe", 8'h00, p2_oe);
      rd("unmapped", 16'hff10, 8'h00);
      wr(ADDR_P0_DIR, 8'h00);
      wr(ADDR_P0_LATCH, 8'h05);
      wait_flag(1'b0);
      chk("p0_int_req", 8'h05, {4'h0, p0_int_req});
      wr(ADDR_P0_PU, 8'h0f);
      wr(ADDR_P0_DIR, 8'h0c);
      ext_en[3:2] <= 2'b00;
      settle;
      chk("p0_oe", 8'h03, {4'h0, p0_oe});
      chk("p0_pu", 8'h0c, {4'h0, p0_pu});
      rd("p0 read", ADDR_P0_LATCH, 8'h0d);
      rd("p0 dir", ADDR_P0_DIR, 8'hfc);
      @(posedge clk);
      p1_in <= 8'h3c;
      rd("p1 read", ADDR_P1_PINS, 8'h3c);
      wr(ADDR_P2_PU, 8'h0f);
      settle;
      chk("p2_pu in", 8'h0f, p2_pu);
      wr(ADDR_P2_LATCH, 8'ha5);
      wr(ADDR_P2_DIR, 8'h00);
      settle;
      chk("p2_oe", 8'hff, p2_oe);
      chk("p2_out", 8'ha5, p2_out);
      chk("p2_pu out", 8'h00, p2_pu);
      wr(ADDR_DRV_TYPE, 8'h07);
      settle;
      chk("p2_oe drain", 8'hfa, p2_oe);
      wr(ADDR_P5_DIR, 8'h00);
      wr(ADDR_P5_DIR, 8'h08, 1'b1, 3'h3);
      wr(ADDR_P5_PU, 8'hff);
      wr(ADDR_P5_LATCH, 8'h3c);
      settle;
      chk("p5_oe", 8'hf7, p5_oe);
      chk("p5_pu", 8'h08, p5_pu);
      chk("p5_out", 8'h3c, p5_out);
      rd("p5 dir", ADDR_P5_DIR, 8'h08);
      wr(ADDR_P6_DIR, 8'h0f);
      wr(ADDR_P6_PU, 8'hff);
      wr(ADDR_P7_DIR, 8'h01);
      wr(ADDR_P7_PU, 8'hff);
      wr(ADDR_P6_LATCH, 8'h5a);
      wr(ADDR_P7_LATCH, 8'hfe);
      settle;
      chk("p6_oe", 8'hf0, p6_oe);
      chk("p6_pu", 8'h0f, p6_pu);
      chk("p7_oe", 8'h02, {6'h0, p7_oe});
      chk("p7_pu", 8'h01, {6'h0, p7_pu});
      chk("p6_out", 8'h5a, p6_out);
      chk("p7_out", 8'h02, {6'h0, p7_out});
      rd("p7 dir", ADDR_P7_DIR, 8'hfd);
      rd("p7 pu", ADDR_P7_PU, 8'h03);
      rd("p2 dir", ADDR_P2_DIR, 8'h00);
      wr(ADDR_KEY_RET, 8'h01);
      rd("key ctl", ADDR_KEY_RET, 8'h01);
      chk("key idle", 8'h00, {7'h0, key_int_req});
      @(posedge clk);
      ext[14] <= 1'b0;
      wait_flag(1'b1);
      chk("key low", 8'h01, {7'h0, key_int_req});
      wr(ADDR_P4_LATCH, 8'h81);
      wr(ADDR_P4_PU, 8'hff);
      wr(ADDR_P4_DIR, 8'h00);
      settle;
      chk("p4_oe", 8'h00, p4_oe);
      chk("p4_pu in", 8'hff, p4_pu);
      wr(ADDR_MEM_EXP, 8'h00);
      settle;
      chk("p4_oe out", 8'hff, p4_oe);
      chk("key out", 8'h00, {7'h0, key_int_req});
      chk("p4_out", 8'h81, p4_out);
      chk("p4_pu out", 8'h00, p4_pu);
      rd("p4 read", ADDR_P4_LATCH, 8'h81);
      complete_run;
   end
endmodule // mpk_port_block_bench
